/* File: rtl/sar_seq_pkg.sv */
package sar_seq_pkg;
  // ==========================================
  // widths
  localparam int RESULT_W = 16;
  localparam int BYTE_W = 8;
  localparam int BIT_CNT_W = 5;
  // ==========================================
  // timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int CONV_MAX_NS = 4700;
  // longest time rounds down
  localparam int CONV_MAX_CYC = CONV_MAX_NS / CLK_PERIOD_NS;
  localparam int SAR_STEPS = RESULT_W;
  // one cycle to start, one per bit, one to finish
  localparam int CONV_USED_CYC = SAR_STEPS + 2;
  localparam logic [BIT_CNT_W-1:0] BIT_LAST = 5'h0F;
  localparam logic [BIT_CNT_W-1:0] BIT_ZERO = 5'h00;
  localparam int WAKE_MIN_NS = 12000000;
  // ==========================================
  // coding
  localparam logic [RESULT_W-1:0] OFFSET_FLIP = 16'h8000;
  localparam logic [RESULT_W-1:0] RESULT_RST = 16'h0000;
  localparam logic [BYTE_W-1:0] BYTE_RST = 8'h00;

  // gray codes along idle-acquire-convert-done path
  typedef enum logic [2:0] {
    ST_SHUTDOWN = 3'h0,
    ST_ACQUIRE = 3'h1,
    ST_CONVERT = 3'h3,
    ST_DONE = 3'h2,
    ST_READ = 3'h6,
    ST_STANDBY = 3'h4
  } seq_state_t;
endpackage

/* File: rtl/sar_bit_engine.sv */
`timescale 1ns/100ps
// successive approximation register, one bit per clock
module sar_bit_engine (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic start,
  input wire logic comp_hi,
  output logic [sar_seq_pkg::RESULT_W-1:0] trial,
  output logic busy,
  output logic done
);
  logic [sar_seq_pkg::RESULT_W-1:0] sar_ff;
  logic [sar_seq_pkg::BIT_CNT_W-1:0] bit_ff;
  logic busy_ff;
  logic done_ff;

  assign trial = sar_ff;
  assign busy = busy_ff;
  assign done = done_ff;

  // ==========================================
  // bit trial loop, msb first
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      sar_ff <= sar_seq_pkg::RESULT_RST;
      bit_ff <= sar_seq_pkg::BIT_ZERO;
      busy_ff <= 1'b0;
      done_ff <= 1'b0;
    end else begin
      done_ff <= 1'b0;
      if (start && !busy_ff) begin
        sar_ff <= sar_seq_pkg::OFFSET_FLIP; // midscale trial
        bit_ff <= sar_seq_pkg::BIT_LAST;
        busy_ff <= 1'b1;
      end else if (busy_ff) begin
        // keep or drop current bit, set next one
        if (!comp_hi) begin
          sar_ff[bit_ff[3:0]] <= 1'b0;
        end
        if (bit_ff != sar_seq_pkg::BIT_ZERO) begin
          sar_ff[bit_ff[3:0] - 4'h1] <= 1'b1;
          bit_ff <= bit_ff - 5'h01;
        end else begin
          busy_ff <= 1'b0;
          done_ff <= 1'b1;
        end
      end
    end
  end
endmodule

/* File: rtl/sar_adc_parallel_sequencer.sv */
`timescale 1ns/100ps
module sar_adc_parallel_sequencer #(
  parameter bit BIPOLAR = 1'b1
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic convert_strobe_n,
  input wire logic read_convert_sel,
  input wire logic byte_select,
  input wire logic comp_hi,
  output logic [sar_seq_pkg::RESULT_W-1:0] dac_code,
  output logic track_hold,
  output logic ref_power,
  output logic conversion_done_n,
  output logic [sar_seq_pkg::BYTE_W-1:0] data_out,
  output logic data_oe
);
  // ==========================================
  // pin synchronisers
  logic [1:0] strobe_sync_ff;
  logic [1:0] sel_sync_ff;
  logic [1:0] byte_sync_ff;
  logic strobe_prev_ff;
  logic strobe_fall;
  logic strobe_rise;

  // two stages before any logic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      strobe_sync_ff <= 2'h3;
      sel_sync_ff <= 2'h0;
      byte_sync_ff <= 2'h0;
      strobe_prev_ff <= 1'b1;
    end else begin
      strobe_sync_ff <= {strobe_sync_ff[0], convert_strobe_n};
      sel_sync_ff <= {sel_sync_ff[0], read_convert_sel};
      byte_sync_ff <= {byte_sync_ff[0], byte_select};
      strobe_prev_ff <= strobe_sync_ff[1];
    end
  end

  assign strobe_fall = strobe_prev_ff && !strobe_sync_ff[1];
  assign strobe_rise = !strobe_prev_ff && strobe_sync_ff[1];

  // ==========================================
  // sequencer state
  sar_seq_pkg::seq_state_t state_ff;
  sar_seq_pkg::seq_state_t nxt_state;
  logic shutdown_sel_ff;
  logic eng_start;
  logic eng_busy;
  logic eng_done;
  logic [sar_seq_pkg::RESULT_W-1:0] eng_trial;
  logic [sar_seq_pkg::RESULT_W-1:0] result_ff;
  logic sel_now;

  assign sel_now = sel_sync_ff[1];
  assign eng_start = (state_ff == sar_seq_pkg::ST_ACQUIRE) && strobe_fall;

  // next state from strobe edges and the engine done pulse
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      sar_seq_pkg::ST_SHUTDOWN: begin
        if (strobe_fall && !sel_now) begin
          nxt_state = sar_seq_pkg::ST_ACQUIRE;
        end
      end
      sar_seq_pkg::ST_STANDBY: begin
        if (strobe_fall && !sel_now) begin
          nxt_state = sar_seq_pkg::ST_ACQUIRE;
        end
      end
      sar_seq_pkg::ST_ACQUIRE: begin
        if (strobe_fall) begin
          nxt_state = sar_seq_pkg::ST_CONVERT;
        end
      end
      sar_seq_pkg::ST_CONVERT: begin
        if (eng_done) begin
          nxt_state = sar_seq_pkg::ST_DONE;
        end
      end
      sar_seq_pkg::ST_DONE: begin
        if (strobe_fall && sel_now) begin
          nxt_state = sar_seq_pkg::ST_READ;
        end else if (strobe_fall) begin
          nxt_state = sar_seq_pkg::ST_ACQUIRE; // skip readout, new cycle
        end
      end
      sar_seq_pkg::ST_READ: begin
        if (strobe_rise) begin
          nxt_state = shutdown_sel_ff ? sar_seq_pkg::ST_SHUTDOWN : sar_seq_pkg::ST_STANDBY;
        end
      end
      default: begin
        nxt_state = sar_seq_pkg::ST_SHUTDOWN;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state_ff <= sar_seq_pkg::ST_SHUTDOWN;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // latch power-down choice at second edge
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      shutdown_sel_ff <= 1'b1;
    end else if (eng_start) begin
      shutdown_sel_ff <= sel_now;
    end
  end

  // ==========================================
  // conversion engine on internal clock
  sar_bit_engine u_engine (
    .clk(clk),
    .arst_n(arst_n),
    .start(eng_start),
    .comp_hi(comp_hi),
    .trial(eng_trial),
    .busy(eng_busy),
    .done(eng_done)
  );

  // trial word straight from the engine register, comparator judges the live trial
  assign dac_code = eng_trial;

  // capture result with output coding
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      result_ff <= sar_seq_pkg::RESULT_RST;
    end else if (eng_done) begin
      // offset binary flips the msb for unipolar parts, bipolar parts keep the trial word
      result_ff <= BIPOLAR ? eng_trial : (eng_trial ^ sar_seq_pkg::OFFSET_FLIP);
    end
  end

  // ==========================================
  // registered outputs
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      track_hold <= 1'b0;
      ref_power <= 1'b0;
      conversion_done_n <= 1'b1;
    end else begin
      track_hold <= (nxt_state == sar_seq_pkg::ST_ACQUIRE);
      // reference off only in shutdown
      ref_power <= (nxt_state != sar_seq_pkg::ST_SHUTDOWN);
      conversion_done_n <= !(nxt_state == sar_seq_pkg::ST_DONE ||
                             nxt_state == sar_seq_pkg::ST_READ);
    end
  end

  // data bus drive and byte steering
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      data_out <= sar_seq_pkg::BYTE_RST;
      data_oe <= 1'b0;
    end else begin
      data_oe <= (nxt_state == sar_seq_pkg::ST_READ);
      if (byte_sync_ff[1]) begin
        data_out <= result_ff[15:8];
      end else begin
        data_out <= result_ff[7:0];
      end
    end
  end

  // ==========================================
  // checks
  logic [7:0] conv_cnt_ff;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      conv_cnt_ff <= 8'h00;
    end else if (state_ff == sar_seq_pkg::ST_CONVERT) begin
      conv_cnt_ff <= conv_cnt_ff + 8'h01;
    end else begin
      conv_cnt_ff <= 8'h00;
    end
  end

  sequence s_hold_entry;
    state_ff == sar_seq_pkg::ST_ACQUIRE && strobe_fall;
  endsequence

  sequence s_done_low;
    ##[1:20] !conversion_done_n;
  endsequence

  a_conv_time_bound: assert property (@(posedge clk) disable iff (!arst_n)
    s_hold_entry |-> s_done_low) else $error("conversion too slow");
  a_conv_cnt_limit: assert property (@(posedge clk) disable iff (!arst_n)
    conv_cnt_ff < 8'h2E) else $error("conversion exceeds limit");
  a_ignore_high_sel: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_SHUTDOWN && strobe_fall && sel_now) |=>
    state_ff == sar_seq_pkg::ST_SHUTDOWN) else $error("high select not ignored");
  a_wake_acquire: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff != sar_seq_pkg::ST_ACQUIRE && nxt_state == sar_seq_pkg::ST_ACQUIRE) |=>
    track_hold && ref_power) else $error("no acquisition on wake");
  a_hold_on_start: assert property (@(posedge clk) disable iff (!arst_n)
    eng_start |=> !track_hold && eng_busy) else $error("hold not entered");
  a_bus_float: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_ACQUIRE || state_ff == sar_seq_pkg::ST_CONVERT) |->
    !data_oe) else $error("bus driven early");
  a_read_drive: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_DONE && strobe_fall && sel_now) |=> data_oe)
    else $error("read did not drive bus");
  a_mode_choice: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_READ && strobe_rise) |=>
    (ref_power == !shutdown_sel_ff)) else $error("wrong power-down mode");
  a_byte_steer: assert property (@(posedge clk) disable iff (!arst_n)
    $stable(result_ff) && $stable(byte_sync_ff[1]) |=>
    data_out == ($past(byte_sync_ff[1]) ? $past(result_ff[15:8]) : $past(result_ff[7:0])))
    else $error("wrong byte on bus");
  a_standby_wake: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_STANDBY && strobe_fall && !sel_now) |=>
    state_ff == sar_seq_pkg::ST_ACQUIRE) else $error("standby wake failed");

  // ==========================================
  // power state, done flag and coding checks
  sequence s_standby_high;
    state_ff == sar_seq_pkg::ST_STANDBY && strobe_fall && sel_now;
  endsequence

  sequence s_shutdown_wake;
    state_ff == sar_seq_pkg::ST_SHUTDOWN && strobe_fall && !sel_now;
  endsequence

  sequence s_read_release;
    state_ff == sar_seq_pkg::ST_READ && strobe_rise;
  endsequence

  // edges that leave a power state alone or wake it
  a_standby_ignore: assert property (@(posedge clk) disable iff (!arst_n)
    s_standby_high |=> state_ff == sar_seq_pkg::ST_STANDBY && !track_hold)
    else $error("high select not ignored in standby");
  a_shutdown_wake: assert property (@(posedge clk) disable iff (!arst_n)
    s_shutdown_wake |=> state_ff == sar_seq_pkg::ST_ACQUIRE && ref_power && track_hold)
    else $error("shutdown wake failed");
  a_ref_off_idle: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff == sar_seq_pkg::ST_SHUTDOWN |-> !ref_power)
    else $error("reference on in shutdown");
  a_ref_on_standby: assert property (@(posedge clk) disable iff (!arst_n)
    state_ff == sar_seq_pkg::ST_STANDBY |-> ref_power)
    else $error("reference off in standby");
  a_select_latch: assert property (@(posedge clk) disable iff (!arst_n)
    eng_start |=> shutdown_sel_ff == $past(sel_now))
    else $error("mode select not latched");

  // done flag rises with the engine and stands until the bus is released or a select-low strobe fall starts a new acquisition
  a_done_flag: assert property (@(posedge clk) disable iff (!arst_n)
    eng_done |=> !conversion_done_n && state_ff == sar_seq_pkg::ST_DONE)
    else $error("done flag not raised");
  a_done_stands: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_DONE && !strobe_fall) |=> !conversion_done_n)
    else $error("done flag dropped early");
  a_done_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_ACQUIRE || state_ff == sar_seq_pkg::ST_CONVERT) |->
    conversion_done_n) else $error("done flag during conversion");
  a_release_bus: assert property (@(posedge clk) disable iff (!arst_n)
    s_read_release |=> !data_oe && conversion_done_n)
    else $error("bus not released on strobe rise");
  a_data_idle: assert property (@(posedge clk) disable iff (!arst_n)
    (state_ff == sar_seq_pkg::ST_SHUTDOWN || state_ff == sar_seq_pkg::ST_STANDBY) |->
    !data_oe) else $error("bus driven while idle");

  // engine only converts, tracking only acquires
  a_engine_window: assert property (@(posedge clk) disable iff (!arst_n)
    eng_busy |-> state_ff == sar_seq_pkg::ST_CONVERT)
    else $error("engine busy outside conversion");
  a_track_window: assert property (@(posedge clk) disable iff (!arst_n)
    track_hold |-> state_ff == sar_seq_pkg::ST_ACQUIRE)
    else $error("tracking outside acquisition");

  // output coding and data line order
  a_result_coding: assert property (@(posedge clk) disable iff (!arst_n)
    eng_done |=> result_ff[15] == ($past(eng_trial[15]) ^ !BIPOLAR) &&
    result_ff[14:0] == $past(eng_trial[14:0])) else $error("wrong output coding");
  a_lsb_line: assert property (@(posedge clk) disable iff (!arst_n)
    byte_sync_ff[1] |=> data_out[0] == $past(result_ff[8]))
    else $error("upper byte lsb misplaced");
  a_lsb_line_low: assert property (@(posedge clk) disable iff (!arst_n)
    !byte_sync_ff[1] |=> data_out[0] == $past(result_ff[0]))
    else $error("lower byte lsb misplaced");
endmodule

/* File: verification/sar_host_model.sv */
`timescale 1ns/100ps
// ==========================================
// host controller on the strobe, select and byte lines
module sar_host_model #(
  parameter int WAKE_CYC = 20
) (
  input wire logic clk,
  input wire logic conversion_done_n,
  output logic convert_strobe_n,
  output logic read_convert_sel,
  output logic byte_select
);
  // idle levels at time zero
  initial begin
    convert_strobe_n = 1'b1;
    read_convert_sel = 1'b0;
    byte_select = 1'b0;
  end
  // select settles first, then strobe drops; each level held six cycles
  task automatic fall(input logic sel);
    @(posedge clk);
    #1 read_convert_sel = sel;
    repeat (6) @(posedge clk);
    #1 convert_strobe_n = 1'b0;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // strobe back high, held six cycles
  task automatic rise();
    @(posedge clk);
    #1 convert_strobe_n = 1'b1;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // byte choice, given time to reach the data lines
  task automatic pick_byte(input logic hi);
    @(posedge clk);
    #1 byte_select = hi;
    repeat (6) @(posedge clk);
    #1;
  endtask
  // reference settling pause after waking from shutdown
  task automatic wake_wait();
    repeat (WAKE_CYC) @(posedge clk);
    #1;
  endtask
  // readout strobe only once done has fallen, bounded wait
  task automatic read_start();
    for (int i = 0; i < 60 && conversion_done_n !== 1'b0; i++) @(posedge clk);
    fall(1'b1);
  endtask
endmodule

/* File: verification/sar_adc_parallel_sequencer_tb.sv */
`timescale 1ns/100ps
`define CHECK(name, exp, got) begin checked++; if ((got) !== (exp)) begin fails++; \
  $display("CHECK FAILED %s expected %h seen %h", name, exp, got); end end
// ==========================================
// bench for the conversion sequencer
module sar_adc_parallel_sequencer_tb;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic convert_strobe_n;
  logic read_convert_sel;
  logic byte_select;
  logic comp_hi;
  logic [sar_seq_pkg::RESULT_W-1:0] dac_code;
  logic [sar_seq_pkg::RESULT_W-1:0] analog_in = 16'h0000;
  logic track_hold;
  logic ref_power;
  logic conversion_done_n;
  logic [sar_seq_pkg::BYTE_W-1:0] data_out;
  logic data_oe;
  int fails = 0;
  int checked = 0;
  // 10 MHz clock
  always #50 clk = ~clk;
  // comparator keeps a trial bit while the trial is not above the input
  assign comp_hi = (dac_code <= analog_in);
  sar_host_model #(.WAKE_CYC(20)) host (.clk(clk), .conversion_done_n(conversion_done_n),
    .convert_strobe_n(convert_strobe_n), .read_convert_sel(read_convert_sel),
    .byte_select(byte_select));
  sar_adc_parallel_sequencer #(.BIPOLAR(1'b1)) DUT (.clk(clk), .arst_n(arst_n),
    .convert_strobe_n(convert_strobe_n), .read_convert_sel(read_convert_sel),
    .byte_select(byte_select), .comp_hi(comp_hi), .dac_code(dac_code),
    .track_hold(track_hold), .ref_power(ref_power), .conversion_done_n(conversion_done_n),
    .data_out(data_out), .data_oe(data_oe));
  // ==========================================
  // verdict
  task automatic stop_test();
    if (fails == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // scenarios
  task automatic check_reset();
    `CHECK("track_hold", 1'b0, track_hold)
    `CHECK("ref_power", 1'b0, ref_power)
    `CHECK("done_n", 1'b1, conversion_done_n)
    `CHECK("data_oe", 1'b0, data_oe)
    `CHECK("dac_code", 16'h0000, dac_code)
  endtask
  task automatic ignore_high();
    host.fall(1'b1);
    `CHECK("track_hold", 1'b0, track_hold)
    `CHECK("ref_power", 1'b0, ref_power)
    host.rise();
  endtask
  // sample, convert, bounded wait for done, then strobe up
  task automatic convert(input logic mode, input logic [15:0] val);
    analog_in = val;
    host.fall(mode);
    `CHECK("track_hold", 1'b0, track_hold)
    `CHECK("data_oe", 1'b0, data_oe)
    for (int i = 0; i < 41 && conversion_done_n !== 1'b0; i++) @(posedge clk);
    #1;
    `CHECK("done_n", 1'b0, conversion_done_n)
    `CHECK("data_oe", 1'b0, data_oe)
    `CHECK("dac_code", val, dac_code)
    host.rise();
  endtask
  // both bytes read, bus released on strobe rise
  task automatic read_out(input logic mode, input logic [15:0] val);
    logic [15:0] w;
    w = val; // bipolar part: the converted trip word is the code
    host.pick_byte(1'b1);
    host.read_start();
    `CHECK("data_oe", 1'b1, data_oe)
    `CHECK("upper", w[15:8], data_out)
    host.pick_byte(1'b0);
    `CHECK("lower", w[7:0], data_out)
    host.rise();
    `CHECK("data_oe", 1'b0, data_oe)
    `CHECK("done_n", 1'b1, conversion_done_n)
    `CHECK("ref_power", ~mode, ref_power)
  endtask
  task automatic shutdown_cycle();
    host.fall(1'b0);
    `CHECK("track_hold", 1'b1, track_hold)
    `CHECK("ref_power", 1'b1, ref_power)
    `CHECK("data_oe", 1'b0, data_oe)
    host.rise();
    host.wake_wait();
    convert(1'b1, 16'hA5C3);
    read_out(1'b1, 16'hA5C3);
  endtask
  task automatic standby_cycle();
    host.fall(1'b0);
    host.rise();
    convert(1'b0, 16'h3A96);
    read_out(1'b0, 16'h3A96);
    host.fall(1'b1);
    `CHECK("track_hold", 1'b0, track_hold)
    `CHECK("ref_power", 1'b1, ref_power)
    host.rise();
    host.fall(1'b0);
    `CHECK("track_hold", 1'b1, track_hold)
    `CHECK("ref_power", 1'b1, ref_power)
    host.rise();
  endtask
  // ==========================================
  // main sequence
  initial begin
    repeat (6) @(posedge clk);
    #1 arst_n = 1'b1;
    check_reset();
    ignore_high();
    shutdown_cycle();
    standby_cycle();
    stop_test();
  end
  // watchdog against a hang
  initial begin
    repeat (3000) @(posedge clk);
    fails++;
    stop_test();
  end
endmodule
